/* File: design/sar_adc_serial_readout.sv */
// SAR converter control with serial readout and chain mode.
// Assumes convert strobe, serial clock, chain select and read-enable are
// asynchronous pins; comparator decision arrives from analog on clk.
`timescale 1ns/1ns

// Contract
// - Select low: pin gates serial output
// - Select high: pin is chain data input
// - Convert rising edge starts conversion
// - Power down while strobe stays high
// - Strobe low powers up, rearms
// - Busy high during conversion only
// - One bit per rising serial clock
// - Output carries result or chain data
// - Result is two's complement
// - Sixteen-step successive approximation on DAC
// - Result loaded for serial transfer
// - Acquire next sample during conversion
// - Internal oscillator times conversion
// - Result readable right after conversion
module sar_adc_serial_readout
  import sar_adc_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Host control pins
  input  wire logic        convertStrobe,
  input  wire logic        chainSelect,
  input  wire logic        readEnableChainIn,
  input  wire logic        serialClk,
  // Serial output pin and its enable
  output logic             serialData,
  output logic             serialDataOen,
  // Status
  output logic             busy,
  output logic             powerDown,
  output logic             sampling,
  // Analog front end
  input  wire logic        compGreater,
  output logic [15:0]      capacitiveDac
);

  logic [3:0] pinSync;
  logic       cnvS;
  logic       selS;
  logic       rdlS;
  logic       sckS;

  sync_two_ff #(
    .WIDTH(4)
  ) u_sync (
    .clk    (clk),
    .resetn (resetn),
    .asyncIn({convertStrobe, chainSelect, readEnableChainIn, serialClk}),
    .syncOut(pinSync)
  );

  assign cnvS = pinSync[3];
  assign selS = pinSync[2];
  assign rdlS = pinSync[1];
  assign sckS = pinSync[0];

  logic        cnvPrev_ff;
  logic        sckPrev_ff;
  logic        cnvRise;
  logic        sckRise;
  logic        stepEn;

  conv_state_t state_ff;
  conv_state_t nxt_state;
  logic [15:0] dac_ff;
  logic [15:0] nxt_dac;
  logic [15:0] trial_ff;
  logic [15:0] nxt_trial;
  logic [15:0] shift_ff;
  logic [15:0] nxt_shift;
  logic [4:0]  bitCnt_ff;
  logic [4:0]  nxt_bitCnt;
  logic        sdo_ff;
  logic        nxt_sdo;
  logic [3:0]  hold_ff;
  logic [3:0]  nxt_hold;
  logic        busy_ff;
  logic        nxt_busy;

  assign cnvRise = cnvS && !cnvPrev_ff;
  assign sckRise = sckS && !sckPrev_ff;

  sar_step_timer u_timer (
    .clk   (clk),
    .resetn(resetn),
    .run   (state_ff == ST_CONVERT),
    .stepEn(stepEn)
  );

  always_comb begin
    nxt_state  = state_ff;
    nxt_dac    = dac_ff;
    nxt_trial  = trial_ff;
    nxt_shift  = shift_ff;
    nxt_bitCnt = bitCnt_ff;
    nxt_sdo    = sdo_ff;
    nxt_hold   = hold_ff;
    nxt_busy   = busy_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (cnvRise) begin
          nxt_state = ST_CONVERT;
          nxt_busy  = 1'b1;
          nxt_dac   = DAC_MSB;
          nxt_trial = DAC_MSB;
          nxt_hold  = HOLD_LAST;
        end
      end
      ST_CONVERT: begin
        if (hold_ff != 4'h0) begin
          nxt_hold = hold_ff - 4'h1;
        end
        if (stepEn) begin
          // Keep or drop the trial bit, then try the next lower weight
          if (!compGreater) begin
            nxt_dac = dac_ff & ~trial_ff;
          end
          nxt_trial = trial_ff >> 1;
          nxt_dac   = nxt_dac | (trial_ff >> 1);
          if (trial_ff[0]) begin
            // Offset binary to two's complement by flipping the MSB
            nxt_shift  = {~nxt_dac[15], nxt_dac[14:0]};
            nxt_sdo    = ~nxt_dac[15];
            nxt_bitCnt = 5'h00;
            nxt_busy   = 1'b0;
            nxt_state  = cnvS ? ST_POWERDOWN : ST_IDLE;
          end
        end
      end
      ST_POWERDOWN: begin
        if (!cnvS) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    // Shift path, paused while a conversion runs
    if (sckRise && !busy_ff) begin
      if (selS) begin
        // Own bits first, then upstream data falls through
        nxt_shift = {shift_ff[14:0], rdlS};
        nxt_sdo   = shift_ff[14];
        if (bitCnt_ff != BITS_LAST + 5'h01) begin
          nxt_bitCnt = bitCnt_ff + 5'h01;
        end
      end else if (!rdlS) begin
        nxt_shift = {shift_ff[14:0], 1'b0};
        nxt_sdo   = shift_ff[14];
        if (bitCnt_ff != BITS_LAST + 5'h01) begin
          nxt_bitCnt = bitCnt_ff + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff   <= ST_IDLE;
      dac_ff     <= RESULT_RST;
      trial_ff   <= RESULT_RST;
      shift_ff   <= RESULT_RST;
      bitCnt_ff  <= 5'h00;
      sdo_ff     <= 1'b0;
      hold_ff    <= 4'h0;
      busy_ff    <= 1'b0;
      cnvPrev_ff <= 1'b0;
      sckPrev_ff <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      dac_ff     <= nxt_dac;
      trial_ff   <= nxt_trial;
      shift_ff   <= nxt_shift;
      bitCnt_ff  <= nxt_bitCnt;
      sdo_ff     <= nxt_sdo;
      hold_ff    <= nxt_hold;
      busy_ff    <= nxt_busy;
      cnvPrev_ff <= cnvS;
      sckPrev_ff <= sckS;
    end
  end

  // Chain mode always drives; normal mode drives only with enable low
  assign serialDataOen = !(selS || !rdlS);
  assign serialData    = sdo_ff;
  assign busy          = busy_ff;
  assign powerDown     = (state_ff == ST_POWERDOWN);
  // Input switch closes once the hold window ends, even mid conversion
  assign sampling      = !((state_ff == ST_CONVERT) && (hold_ff != 4'h0));
  assign capacitiveDac = dac_ff;

  chk_busy_on_start: assert property (
    @(posedge clk) disable iff (!resetn)
    (state_ff == ST_IDLE && cnvRise) |=> busy && state_ff == ST_CONVERT)
    else $error("busy not raised at conversion start");

  chk_busy_duration: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(busy) |-> busy [*8] ##1 busy [*8] ##1 !busy)
    else $error("conversion length wrong");

  chk_powerdown_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    (powerDown && cnvS) |=> powerDown)
    else $error("left power down while strobe high");

  chk_powerup_low: assert property (
    @(posedge clk) disable iff (!resetn)
    (powerDown && !cnvS) |=> state_ff == ST_IDLE)
    else $error("no power up on strobe low");

  chk_msb_ready: assert property (
    @(posedge clk) disable iff (!resetn)
    $fell(busy) |-> serialData == shift_ff[15])
    else $error("msb not ready at busy fall");

  chk_twos_comp: assert property (
    @(posedge clk) disable iff (!resetn)
    $fell(busy) |-> shift_ff == {~dac_ff[15], dac_ff[14:0]})
    else $error("result not two's complement");

  chk_shift_step: assert property (
    @(posedge clk) disable iff (!resetn)
    (sckRise && !busy && !selS && !rdlS) |=> serialData == $past(shift_ff[14]))
    else $error("serial bit not shifted");

  chk_chain_in: assert property (
    @(posedge clk) disable iff (!resetn)
    (sckRise && !busy && selS) |=> shift_ff[0] == $past(rdlS))
    else $error("chain data not captured");

  chk_oe_normal: assert property (
    @(posedge clk) disable iff (!resetn)
    (!selS && rdlS) |-> serialDataOen)
    else $error("output driven while disabled");

  chk_oe_chain: assert property (
    @(posedge clk) disable iff (!resetn)
    selS |-> !serialDataOen)
    else $error("chain mode output not driven");

  chk_oe_enabled: assert property (
    @(posedge clk) disable iff (!resetn)
    (!selS && !rdlS) |-> !serialDataOen)
    else $error("normal mode output not driven");

  chk_hold_window: assert property (
    @(posedge clk) disable iff (!resetn)
    $rose(busy) |-> !sampling [*6] ##1 sampling)
    else $error("hold window length wrong");

  chk_dac_start: assert property (
    @(posedge clk) disable iff (!resetn)
    (state_ff == ST_IDLE && cnvRise) |=> capacitiveDac == DAC_MSB)
    else $error("first trial not mid scale");

  chk_dac_keep: assert property (
    @(posedge clk) disable iff (!resetn)
    (busy && stepEn && compGreater) |=> (capacitiveDac & $past(trial_ff)) != 16'h0000)
    else $error("kept trial bit lost");

  chk_dac_drop: assert property (
    @(posedge clk) disable iff (!resetn)
    (busy && stepEn && !compGreater) |=> (capacitiveDac & $past(trial_ff)) == 16'h0000)
    else $error("rejected trial bit kept");

  chk_trial_walk: assert property (
    @(posedge clk) disable iff (!resetn)
    (busy && stepEn) |=> trial_ff == ($past(trial_ff) >> 1))
    else $error("trial weight not stepped");

  chk_busy_level: assert property (
    @(posedge clk) disable iff (!resetn)
    busy == (state_ff == ST_CONVERT))
    else $error("busy out of step with conversion");

  chk_powerdown_entry: assert property (
    @(posedge clk) disable iff (!resetn)
    $fell(busy) |-> powerDown == $past(cnvS))
    else $error("power down entry wrong");

  chk_busy_freeze: assert property (
    @(posedge clk) disable iff (!resetn)
    (busy && !trial_ff[0]) |=> $stable(serialData))
    else $error("output moved during conversion");

  chk_disabled_hold: assert property (
    @(posedge clk) disable iff (!resetn)
    (sckRise && !busy && !selS && rdlS) |=> $stable(serialData))
    else $error("shifted while output disabled");

  chk_chain_out: assert property (
    @(posedge clk) disable iff (!resetn)
    (sckRise && !busy && selS) |=> serialData == $past(shift_ff[14]))
    else $error("chain output not shifted");

  chk_count_restart: assert property (
    @(posedge clk) disable iff (!resetn)
    $fell(busy) |-> bitCnt_ff == 5'h00)
    else $error("bit count not restarted");

endmodule

/* File: design/sar_adc_pkg.sv */
// Package: constants, states and timing for the SAR converter readout block.
// Assumes a single 10 MHz system clock; all other rates come from enables.
package sar_adc_pkg;

  localparam int unsigned RESULT_W       = 16;
  localparam int unsigned CLK_PERIOD_NS  = 100;
  // Conversion time budget and oscillator step
  localparam int unsigned CONV_TIME_NS   = 2000;
  localparam int unsigned CONV_CYCLES    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Integer division leaves one clock per step: a conversion takes 16 clocks
  localparam int unsigned STEP_DIV       = CONV_CYCLES / RESULT_W;
  localparam logic [3:0]  STEP_DIV_LAST  = 4'(STEP_DIV - 1);
  // Sampling hold window before acquisition resumes
  localparam int unsigned HOLD_TIME_NS   = 750;
  localparam int unsigned HOLD_CYCLES    = HOLD_TIME_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  HOLD_LAST      = 4'(HOLD_CYCLES - 1);
  localparam logic [15:0] RESULT_RST     = 16'h0000;
  localparam logic [15:0] DAC_MSB        = 16'h8000;
  localparam logic [4:0]  BITS_LAST      = 5'h0F;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_POWERDOWN
  } conv_state_t;

endpackage

/* File: design/sync_two_ff.sv */
// Two-stage synchroniser for a bundle of asynchronous pins.
// Assumes inputs come from outside the clk domain.
`timescale 1ns/1ns
module sync_two_ff #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Data
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
    end
  end

  assign syncOut = sync_ff;

endmodule

/* File: design/sar_step_timer.sv */
// Internal conversion oscillator: divider giving one-cycle step enables.
// Assumes run is held high for the whole conversion.
`timescale 1ns/1ns
module sar_step_timer
  import sar_adc_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Control
  input  wire logic run,
  output logic      stepEn
);

  logic [3:0] div_ff;
  logic [3:0] nxt_div;

  always_comb begin
    nxt_div = 4'h0;
    stepEn  = 1'b0;
    if (run) begin
      if (div_ff == STEP_DIV_LAST) begin
        stepEn = 1'b1;
      end else begin
        nxt_div = div_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_ff <= 4'h0;
    end else begin
      div_ff <= nxt_div;
    end
  end

endmodule

/* File: bench/sar_analog_model.sv */
// Comparator model standing in for the held input sample.
// Assumes the DAC trial code is offset binary, as the control logic drives it.
`timescale 1ns/1ns
module sar_analog_model (
  // Trial code and held sample
  input  wire logic [15:0] capacitiveDac,
  input  wire logic [15:0] target,
  // Decision
  output logic             compGreater
);
  // Keep the trial bit while the sample is at or above the trial level
  assign compGreater = (target >= capacitiveDac);
endmodule

/* File: bench/test_sar_adc_serial_readout.sv */
// Self-checking bench for the converter control and serial readout.
// Assumes a 10 MHz clk and a host serial clock of 800 ns, idle low.
`timescale 1ns/1ns
module test_sar_adc_serial_readout;
  import sar_adc_pkg::*;
  logic        clk, resetn, convertStrobe, chainSelect, readEnableChainIn, serialClk;
  logic        serialData, serialDataOen, busy, powerDown, sampling, compGreater;
  logic [15:0] capacitiveDac, target;
  logic        sdoPin;
  int          num_errors, compares, n;

  sar_adc_serial_readout dut (
    .clk(clk), .resetn(resetn), .convertStrobe(convertStrobe),
    .chainSelect(chainSelect), .readEnableChainIn(readEnableChainIn),
    .serialClk(serialClk), .serialData(serialData), .serialDataOen(serialDataOen),
    .busy(busy), .powerDown(powerDown), .sampling(sampling),
    .compGreater(compGreater), .capacitiveDac(capacitiveDac));

  sar_analog_model model (
    .capacitiveDac(capacitiveDac), .target(target), .compGreater(compGreater));

  // Released pin has no pull: show the inverse so reading a floating line fails
  assign sdoPin = serialDataOen ? ~serialData : serialData;

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Inputs always move 10 ns after the edge, so sampling never races
  task automatic step(input int c);
    repeat (c) @(posedge clk);
    #10;
  endtask

  task automatic check(input logic got, input logic exp, input string msg);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask

  // Serial clock stands low between frames; 4 clk per phase beats the sync delay
  task automatic clk_edge();
    serialClk = 1'b1;
    step(4);
    serialClk = 1'b0;
    step(4);
  endtask

  // Host waits for busy low before reading and before the next edge
  task automatic convert(input logic [15:0] code, input logic expMsb);
    convertStrobe = 1'b0;
    step(4);
    check(powerDown, 1'b0, "still powered down after strobe low");
    target = code;
    convertStrobe = 1'b1;
    n = 0;
    while (busy !== 1'b1 && n < 10) begin
      step(1);
      n++;
    end
    check(busy, 1'b1, "busy did not rise");
    check(sampling, 1'b0, "input not held at conversion start");
    check(capacitiveDac == DAC_MSB, 1'b1, "first trial not mid scale");
    step(10);
    check(sampling, 1'b1, "not acquiring during conversion");
    n = 10;
    while (busy !== 1'b0 && n < 200) begin
      step(1);
      n++;
    end
    check(n == STEP_DIV * RESULT_W, 1'b1, "conversion length");
    check(powerDown, 1'b1, "no power down with strobe high");
    check(capacitiveDac == code, 1'b1, "search did not settle");
    check(sdoPin, expMsb, "first bit not ready at busy fall");
  endtask

  // After edge k the output shows exp[31-k]; upstream bits enter on edges 1..16
  task automatic shift_out(input logic [31:0] exp, input logic [15:0] upIn, input int edges);
    for (int k = 1; k <= edges; k++) begin
      if (chainSelect && k <= 16) begin
        readEnableChainIn = upIn[16-k];
      end
      clk_edge();
      check(sdoPin, exp[31-k], "serial bit");
    end
  endtask

  task automatic report_and_stop();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    step(20000);
    num_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    num_errors = 0;
    compares = 0;
    resetn = 1'b0;
    convertStrobe = 1'b0;
    chainSelect = 1'b0;
    readEnableChainIn = 1'b0;
    serialClk = 1'b0;
    target = 16'h0000;
    step(10);
    resetn = 1'b1;
    step(5);
    convert(16'hC3A5, 1'b0);
    readEnableChainIn = 1'b1;
    step(4);
    check(serialDataOen, 1'b1, "output driven with enable high");
    clk_edge();
    clk_edge();
    readEnableChainIn = 1'b0;
    step(4);
    check(serialDataOen, 1'b0, "output not driven with enable low");
    check(sdoPin, 1'b0, "shifted while disabled");
    shift_out({16'h43A5, 16'h0000}, 16'h0000, 15);
    convert(16'hFFFF, 1'b0);
    shift_out({16'h7FFF, 16'h0000}, 16'h0000, 15);
    convert(16'h0000, 1'b1);
    shift_out({16'h8000, 16'h0000}, 16'h0000, 15);
    convertStrobe = 1'b0;
    step(4);
    chainSelect = 1'b1;
    step(4);
    convert(16'h5A0F, 1'b1);
    shift_out({16'hDA0F, 16'hB2C9}, 16'hB2C9, 31);
    check(serialDataOen, 1'b0, "chain output not driven");
    report_and_stop();
  end
endmodule
